// ===== core/cdc_defines.svh
/*
 Constants for the clock distribution control block: register offsets,
 field positions, reset values and pin role codes.
 Assumes inclusion by bare name from the package and the core module.
*/
// Contract
// - Bit 4 of the sync config register powers down the sync circuit; resets to zero.
// - Bits 6:5 pick the multipurpose pin role; 00 reset default, 10 test only.
// - Writing one to update bit 0 copies buffers to active registers next serial edge.
// - Update bit clears itself; no zero write is needed before another update.
// - The whole PLL section can be powered down under register control.
// - A bypassed output divider is powered down and passes clock as divide by one.
// - Fine delay blocks on both delay outputs stay down unless delay is selected.
// - Each output powers down alone; emitter-coupled outputs have safe and off states.
// - The whole distribution section can be powered down under register control.
// - Powering a block down and up keeps its register settings.
// - Any power down marks sync lost; host must issue a sync to realign.
// - In align role, pin low holds outputs; following rising edge triggers sync.
`ifndef CDC_DEFINES_SVH
`define CDC_DEFINES_SVH
`define CDC_OFS_SYNC_CFG    8'h58
`define CDC_OFS_UNUSED      8'h59
`define CDC_OFS_UPDATE      8'h5a
`define CDC_BIT_SYNC_PD     4
`define CDC_BIT_ROLE_LO     5
`define CDC_BIT_ROLE_HI     6
`define CDC_BIT_UPDATE      0
`define CDC_SYNC_CFG_MASK   8'h7f
`define CDC_SYNC_CFG_RST    8'h00
`define CDC_ROLE_RESET      2'h0
`define CDC_ROLE_ALIGN      2'h1
`define CDC_ROLE_TEST       2'h2
`define CDC_ROLE_PWRDN      2'h3
`endif

// ===== core/cdc_pkg.sv
/*
 Types for the clock distribution control block.
 Assumes cdc_defines.svh is on the include path.
*/
`default_nettype none
`include "cdc_defines.svh"
package cdc_pkg;
   typedef enum logic [1:0] {
      CDC_ROLE_RESET_E = 2'h0,
      CDC_ROLE_ALIGN_E = 2'h1,
      CDC_ROLE_TEST_E  = 2'h2,
      CDC_ROLE_PWRDN_E = 2'h3
   } cdc_pin_role_t;
   // Power state of one emitter-coupled output
   typedef enum logic [1:0] {
      CDC_PECL_ON   = 2'h0,
      CDC_PECL_SAFE = 2'h1,
      CDC_PECL_OFF  = 2'h3
   } cdc_pecl_pd_t;
   typedef enum logic [1:0] {
      CDC_ALIGN_IDLE = 2'h0,
      CDC_ALIGN_HOLD = 2'h1,
      CDC_ALIGN_FIRE = 2'h3
   } cdc_align_st_t;
   typedef struct packed {
      logic       write;
      logic [7:0] addr;
      logic [7:0] data;
   } cdc_wr_t;
endpackage
`default_nettype wire

// ===== core/cdc_ctrl.sv
/*
 Control core: sync config and update strobe registers, buffered to active
 copy, power-down fan-out and multipurpose pin handling.
 Assumes the serial port decoder hands in byte writes and read addresses
 on the MCLK domain; SCLK_RISE carries the serial clock level, and its rising edge is found here.
 The multipurpose pin and SCLK_RISE come from outside and are filtered here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cdc_defines.svh"
module cdc_ctrl
   import cdc_pkg::*;
#(
   parameter int N_PECL = 4,
   parameter int N_LOW  = 4,
   parameter int N_DIV  = 8
)(
   input  wire logic                MCLK,
   input  wire logic                SYS_RST,
   input  wire cdc_wr_t             WR,
   input  wire logic [7:0]          RD_ADDR,
   output logic      [7:0]          RD_DATA,
   input  wire logic                SCLK_RISE,
   input  wire logic                FUNC_PIN,
   input  wire logic                PLL_PD_REQ,
   input  wire logic                DIST_PD_REQ,
   input  wire logic [N_DIV-1:0]    DIV_BYPASS,
   input  wire logic [1:0]          DELAY_SEL,
   input  wire logic [N_PECL*2-1:0] PECL_PD_REQ,
   input  wire logic [N_LOW-1:0]    LOW_PD_REQ,
   output logic                     SYNC_PD,
   output logic      [1:0]          PIN_ROLE,
   output logic                     UPDATE_PULSE,
   output logic                     PLL_PD,
   output logic                     DIST_PD,
   output logic      [N_DIV-1:0]    DIV_PD,
   output logic      [1:0]          DELAY_PD,
   output logic      [N_PECL*2-1:0] PECL_PD,
   output logic      [N_LOW-1:0]    LOW_PD,
   output logic                     OUT_HOLD,
   output logic                     SYNC_TRIG,
   output logic                     SYNC_LOST,
   output logic                     CHIP_RST,
   output logic                     CHIP_PD
);
   // Input filters: three stages, change accepted when stages 2 and 3 agree
   logic [2:0] pin_sync_reg, pin_sync_next;
   logic [2:0] sck_sync_reg, sck_sync_next;
   logic       pin_lvl_reg, pin_lvl_next;
   logic       sck_lvl_reg, sck_lvl_next;
   logic       pin_rise, sck_rise;

   always_comb begin
      pin_sync_next = {pin_sync_reg[1:0], FUNC_PIN};
      sck_sync_next = {sck_sync_reg[1:0], SCLK_RISE};
      pin_lvl_next  = pin_lvl_reg;
      sck_lvl_next  = sck_lvl_reg;
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
         pin_lvl_next = pin_sync_reg[2];
      end
      if (sck_sync_reg[1] == sck_sync_reg[2]) begin
         sck_lvl_next = sck_sync_reg[2];
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         pin_sync_reg <= 3'h7;
         sck_sync_reg <= 3'h0;
         pin_lvl_reg  <= 1'b1;
         sck_lvl_reg  <= 1'b0;
      end else begin
         pin_sync_reg <= pin_sync_next;
         sck_sync_reg <= sck_sync_next;
         pin_lvl_reg  <= pin_lvl_next;
         sck_lvl_reg  <= sck_lvl_next;
      end
   end

   assign pin_rise = pin_lvl_next & ~pin_lvl_reg;
   assign sck_rise = sck_lvl_next & ~sck_lvl_reg;

   // Buffered and active register copies
   logic [7:0] cfg_buf_reg, cfg_buf_next;
   logic [7:0] cfg_act_reg, cfg_act_next;
   logic       upd_pend_reg, upd_pend_next;
   logic       upd_pulse_reg, upd_pulse_next;
   logic [7:0] rd_data_reg, rd_data_next;

   always_comb begin
      cfg_buf_next   = cfg_buf_reg;
      cfg_act_next   = cfg_act_reg;
      upd_pend_next  = upd_pend_reg;
      upd_pulse_next = 1'b0;
      if (WR.write && WR.addr == `CDC_OFS_SYNC_CFG) begin
         cfg_buf_next = WR.data & `CDC_SYNC_CFG_MASK;
      end
      if (upd_pend_reg && sck_rise) begin
         cfg_act_next   = cfg_buf_reg;
         upd_pend_next  = 1'b0;
         upd_pulse_next = 1'b1;
      end
      // A new strobe in the transfer cycle stays pending: set wins
      if (WR.write && WR.addr == `CDC_OFS_UPDATE && WR.data[`CDC_BIT_UPDATE]) begin
         upd_pend_next = 1'b1;
      end
      case (RD_ADDR)
         `CDC_OFS_SYNC_CFG: rd_data_next = cfg_buf_reg;
         `CDC_OFS_UPDATE:   rd_data_next = {7'h00, upd_pend_reg};
         default:           rd_data_next = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         cfg_buf_reg   <= `CDC_SYNC_CFG_RST;
         cfg_act_reg   <= `CDC_SYNC_CFG_RST;
         upd_pend_reg  <= 1'b0;
         upd_pulse_reg <= 1'b0;
         rd_data_reg   <= 8'h00;
      end else begin
         cfg_buf_reg   <= cfg_buf_next;
         cfg_act_reg   <= cfg_act_next;
         upd_pend_reg  <= upd_pend_next;
         upd_pulse_reg <= upd_pulse_next;
         rd_data_reg   <= rd_data_next;
      end
   end

   logic [1:0] role;
   assign role = cfg_act_reg[`CDC_BIT_ROLE_HI:`CDC_BIT_ROLE_LO];

   // Align sequence on the multipurpose pin
   cdc_align_st_t st_reg, st_next;
   logic          hold_next, trig_next, rst_next, pd_pin_next;
   logic          hold_reg, trig_reg, rst_reg, pd_pin_reg;

   always_comb begin
      st_next     = st_reg;
      trig_next   = 1'b0;
      case (st_reg)
         CDC_ALIGN_IDLE: begin
            if (role == `CDC_ROLE_ALIGN && !pin_lvl_next) begin
               st_next = CDC_ALIGN_HOLD;
            end
         end
         CDC_ALIGN_HOLD: begin
            if (role != `CDC_ROLE_ALIGN) begin
               st_next = CDC_ALIGN_IDLE;
            end else if (pin_rise) begin
               st_next   = CDC_ALIGN_FIRE;
               trig_next = 1'b1;
            end
         end
         CDC_ALIGN_FIRE: st_next = CDC_ALIGN_IDLE;
         default:        st_next = CDC_ALIGN_IDLE;
      endcase
      hold_next   = (st_next == CDC_ALIGN_HOLD);
      // Test code drives no pin role at all
      rst_next    = (role == `CDC_ROLE_RESET) && !pin_lvl_next;
      pd_pin_next = (role == `CDC_ROLE_PWRDN) && !pin_lvl_next;
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         st_reg     <= CDC_ALIGN_IDLE;
         hold_reg   <= 1'b0;
         trig_reg   <= 1'b0;
         rst_reg    <= 1'b0;
         pd_pin_reg <= 1'b0;
      end else begin
         st_reg     <= st_next;
         hold_reg   <= hold_next;
         trig_reg   <= trig_next;
         rst_reg    <= rst_next;
         pd_pin_reg <= pd_pin_next;
      end
   end

   // Power-down fan-out; requests gate supplies only, settings stay put
   logic                pll_pd_reg, dist_pd_reg, sync_pd_reg, lost_reg;
   logic                pll_pd_next, dist_pd_next, sync_pd_next, lost_next;
   logic [N_DIV-1:0]    div_pd_reg, div_pd_next;
   logic [1:0]          dly_pd_reg, dly_pd_next;
   logic [N_PECL*2-1:0] pecl_pd_reg, pecl_pd_next;
   logic [N_LOW-1:0]    low_pd_reg, low_pd_next;
   logic                any_pd_rise;

   genvar g;
   generate
      for (g = 0; g < N_PECL; g++) begin : g_pecl
         // Code 10 has no meaning; treated as safe, the gentler state
         // One continuous driver per slice, so no two processes share the vector
         assign pecl_pd_next[2*g+1:2*g] =
            (PECL_PD_REQ[2*g+1:2*g] == 2'h0) ? CDC_PECL_ON  :
            (PECL_PD_REQ[2*g+1:2*g] == 2'h3) ? CDC_PECL_OFF :
                                               CDC_PECL_SAFE;
      end
   endgenerate

   always_comb begin
      pll_pd_next  = PLL_PD_REQ | pd_pin_reg;
      dist_pd_next = DIST_PD_REQ | pd_pin_reg;
      sync_pd_next = cfg_act_reg[`CDC_BIT_SYNC_PD];
      div_pd_next  = DIV_BYPASS;
      dly_pd_next  = ~DELAY_SEL;
      low_pd_next  = LOW_PD_REQ;
      any_pd_rise  = (pll_pd_next & ~pll_pd_reg) | (dist_pd_next & ~dist_pd_reg)
                   | |(pecl_pd_next & ~pecl_pd_reg) | |(low_pd_next & ~low_pd_reg)
                   | (sync_pd_next & ~sync_pd_reg)
                   | |(div_pd_next & ~div_pd_reg) | |(dly_pd_next & ~dly_pd_reg);
      lost_next    = lost_reg;
      if (trig_reg) begin
         lost_next = 1'b0;
      end
      if (any_pd_rise) begin
         lost_next = 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         pll_pd_reg  <= 1'b0;
         dist_pd_reg <= 1'b0;
         sync_pd_reg <= 1'b0;
         lost_reg    <= 1'b0;
         div_pd_reg  <= '0;
         dly_pd_reg  <= 2'h3;
         pecl_pd_reg <= '0;
         low_pd_reg  <= '0;
      end else begin
         pll_pd_reg  <= pll_pd_next;
         dist_pd_reg <= dist_pd_next;
         sync_pd_reg <= sync_pd_next;
         lost_reg    <= lost_next;
         div_pd_reg  <= div_pd_next;
         dly_pd_reg  <= dly_pd_next;
         pecl_pd_reg <= pecl_pd_next;
         low_pd_reg  <= low_pd_next;
      end
   end

   assign RD_DATA      = rd_data_reg;
   assign SYNC_PD      = sync_pd_reg;
   assign PIN_ROLE     = cfg_act_reg[`CDC_BIT_ROLE_HI:`CDC_BIT_ROLE_LO];
   assign UPDATE_PULSE = upd_pulse_reg;
   assign PLL_PD       = pll_pd_reg;
   assign DIST_PD      = dist_pd_reg;
   assign DIV_PD       = div_pd_reg;
   assign DELAY_PD     = dly_pd_reg;
   assign PECL_PD      = pecl_pd_reg;
   assign LOW_PD       = low_pd_reg;
   assign OUT_HOLD     = hold_reg;
   assign SYNC_TRIG    = trig_reg;
   assign SYNC_LOST    = lost_reg;
   assign CHIP_RST     = rst_reg;
   assign CHIP_PD      = pd_pin_reg;

   property p_upd_copy;
      @(posedge MCLK) disable iff (SYS_RST)
      (upd_pend_reg && sck_rise) |=> (cfg_act_reg == $past(cfg_buf_reg)) && UPDATE_PULSE;
   endproperty
   a_upd_copy: assert property (p_upd_copy) else $error("update copy missed");

   property p_upd_clear;
      @(posedge MCLK) disable iff (SYS_RST)
      UPDATE_PULSE && !$past(WR.write) |-> !upd_pend_reg;
   endproperty
   a_upd_clear: assert property (p_upd_clear) else $error("strobe not cleared");

   property p_no_copy;
      @(posedge MCLK) disable iff (SYS_RST)
      !$past(upd_pend_reg) |-> $stable(cfg_act_reg);
   endproperty
   a_no_copy: assert property (p_no_copy) else $error("active changed w/o update");

   property p_sync_pd;
      @(posedge MCLK) disable iff (SYS_RST)
      ##1 SYNC_PD == $past(cfg_act_reg[`CDC_BIT_SYNC_PD]);
   endproperty
   a_sync_pd: assert property (p_sync_pd) else $error("sync power-down wrong");

   property p_unused;
      @(posedge MCLK) disable iff (SYS_RST)
      !cfg_buf_reg[7] and (RD_ADDR == `CDC_OFS_UNUSED |=> RD_DATA == 8'h00);
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits not zero");

   property p_div_pd;
      @(posedge MCLK) disable iff (SYS_RST)
      ##1 DIV_PD == $past(DIV_BYPASS) && DELAY_PD == ~$past(DELAY_SEL);
   endproperty
   a_div_pd: assert property (p_div_pd) else $error("divider/delay pd wrong");

   property p_lost;
      @(posedge MCLK) disable iff (SYS_RST)
      $rose(PLL_PD) || $rose(DIST_PD) |-> SYNC_LOST;
   endproperty
   a_lost: assert property (p_lost) else $error("sync loss not flagged");

   property p_align;
      @(posedge MCLK) disable iff (SYS_RST)
      SYNC_TRIG |-> $past(OUT_HOLD) && !OUT_HOLD;
   endproperty
   a_align: assert property (p_align) else $error("trigger without hold");

   property p_pll_pd;
      @(posedge MCLK) disable iff (SYS_RST)
      PLL_PD_REQ |=> PLL_PD && DIST_PD == ($past(DIST_PD_REQ) | $past(pd_pin_reg));
   endproperty
   a_pll_pd: assert property (p_pll_pd) else $error("pll pd not followed");
endmodule
`default_nettype wire

// ===== testbench/cdc_host_model.sv
/*
 Host model: byte writes, reads, serial clock level and the multipurpose pin.
 Assumes a free running MCLK and tasks called one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module cdc_host_model
   import cdc_pkg::*;
(
   input  wire logic       MCLK,
   input  wire logic [7:0] RD_DATA,
   input  wire logic       UPDATE_PULSE,
   input  wire logic       SYNC_TRIG,
   output var  cdc_wr_t    WR,
   output var  logic [7:0] RD_ADDR,
   output var  logic       SCLK_RISE,
   output var  logic       FUNC_PIN
);
   initial begin
      WR = '0;
      RD_ADDR = 8'h00;
      SCLK_RISE = 1'b0;
      FUNC_PIN = 1'b1;
   end
   // Released bus shows inverted bytes, so a stale value never matches
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK) WR <= '{1'b1, a, d};
      @(posedge MCLK) WR <= '{1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge MCLK) RD_ADDR <= a;
      repeat (2) @(posedge MCLK);
      #1 d = RD_DATA;
   endtask
   // Serial clock stands low outside a frame; one rising edge only
   task automatic sclk(output int n);
      n = 0;
      @(posedge MCLK) SCLK_RISE <= 1'b1;
      repeat (10) begin
         @(posedge MCLK);
         #1 n += int'(UPDATE_PULSE === 1'b1);
      end
      @(posedge MCLK) SCLK_RISE <= 1'b0;
   endtask
   // A low then high pair is the host's align event
   task automatic pin(input logic v, output int n);
      n = 0;
      @(posedge MCLK) FUNC_PIN <= v;
      repeat (10) begin
         @(posedge MCLK);
         #1 n += int'(SYNC_TRIG === 1'b1);
      end
   endtask
endmodule
`default_nettype wire

// ===== testbench/clock_dist_ctrl_update_power_tb_top.sv
/*
 Self-checking bench for cdc_ctrl with the host model on the port side.
 Assumes default parameters of cdc_ctrl.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_dist_ctrl_update_power_tb_top;
   import cdc_pkg::*;
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   cdc_wr_t    wr;
   logic [7:0] rd_addr, rd_data, div_bypass, pecl_pd_req, div_pd, pecl_pd, d;
   logic       sclk_rise, func_pin, pll_pd_req, dist_pd_req, sync_pd, update_pulse;
   logic       pll_pd, dist_pd, out_hold, sync_trig, sync_lost, chip_rst, chip_pd;
   logic [1:0] delay_sel, pin_role, delay_pd;
   logic [3:0] low_pd_req, low_pd;
   logic [1:0] roles [3] = '{2'h1, 2'h3, 2'h0};
   int         miscompares = 0;
   int         checks = 0;
   int         n;
   always #25 mclk = ~mclk;
   cdc_ctrl dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .WR(wr), .RD_ADDR(rd_addr),
      .RD_DATA(rd_data), .SCLK_RISE(sclk_rise), .FUNC_PIN(func_pin),
      .PLL_PD_REQ(pll_pd_req), .DIST_PD_REQ(dist_pd_req), .DIV_BYPASS(div_bypass),
      .DELAY_SEL(delay_sel), .PECL_PD_REQ(pecl_pd_req), .LOW_PD_REQ(low_pd_req),
      .SYNC_PD(sync_pd), .PIN_ROLE(pin_role), .UPDATE_PULSE(update_pulse),
      .PLL_PD(pll_pd), .DIST_PD(dist_pd), .DIV_PD(div_pd), .DELAY_PD(delay_pd),
      .PECL_PD(pecl_pd), .LOW_PD(low_pd), .OUT_HOLD(out_hold), .SYNC_TRIG(sync_trig),
      .SYNC_LOST(sync_lost), .CHIP_RST(chip_rst), .CHIP_PD(chip_pd));
   cdc_host_model host_u (.MCLK(mclk), .RD_DATA(rd_data), .UPDATE_PULSE(update_pulse),
      .SYNC_TRIG(sync_trig), .WR(wr), .RD_ADDR(rd_addr), .SCLK_RISE(sclk_rise),
      .FUNC_PIN(func_pin));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   task automatic upd(input logic [7:0] cfg);
      host_u.wr(8'h58, cfg);
      host_u.wr(8'h5a, 8'h01);
      host_u.sclk(n);
   endtask
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #(2000 * 50);
      miscompares++;
      print_verdict();
   end
   initial begin
      pll_pd_req = 1'b0;
      dist_pd_req = 1'b0;
      div_bypass = 8'h00;
      delay_sel = 2'h0;
      pecl_pd_req = 8'h00;
      low_pd_req = 4'h0;
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk("delay_pd", 8'h03, {6'h00, delay_pd});
      rchk(8'h58, 8'h00);
      rchk(8'h59, 8'h00);
      rchk(8'h5a, 8'h00);
      host_u.wr(8'h58, 8'hff);
      host_u.wr(8'h59, 8'hff);
      host_u.wr(8'h5a, 8'hfe);
      rchk(8'h58, 8'h7f);
      rchk(8'h59, 8'h00);
      rchk(8'h5a, 8'h00);
      chk("sync_pd", 8'h00, {7'h00, sync_pd});
      host_u.wr(8'h5a, 8'h01);
      rchk(8'h5a, 8'h01);
      host_u.sclk(n);
      chk("update pulses", 8'h01, 8'(n));
      chk("sync_pd", 8'h01, {7'h00, sync_pd});
      chk("pin_role", 8'h03, {6'h00, pin_role});
      rchk(8'h5a, 8'h00);
      chk("sync_lost", 8'h01, {7'h00, sync_lost});
      // Roles 01, 11, 00 in turn; code 10 is never written
      for (int i = 0; i < 3; i++) begin
         upd({1'b0, roles[i], 5'h00});
         chk("update pulses", 8'h01, 8'(n));
         chk("pin_role", {6'h00, roles[i]}, {6'h00, pin_role});
         host_u.pin(1'b0, n);
         chk("pin effects", {3'h0, roles[i] == 2'h1, {3{roles[i] == 2'h3}}, roles[i] == 2'h0},
             {3'h0, out_hold, chip_pd, pll_pd, dist_pd, chip_rst});
         host_u.pin(1'b1, n);
         chk("align pulses", {7'h00, roles[i] == 2'h1}, 8'(n));
         if (roles[i] == 2'h1)
            chk("sync_lost", 8'h00, {7'h00, sync_lost});
      end
      upd(8'h20);
      @(posedge mclk);
      pll_pd_req <= 1'b1;
      dist_pd_req <= 1'b1;
      div_bypass <= 8'ha5;
      delay_sel <= 2'h1;
      // Outputs are unterminated here, so the full off code is allowed
      pecl_pd_req <= 8'he4;
      low_pd_req <= 4'h9;
      repeat (3) @(posedge mclk);
      #1;
      chk("pll_pd", 8'h01, {7'h00, pll_pd});
      chk("dist_pd", 8'h01, {7'h00, dist_pd});
      chk("div_pd", 8'ha5, div_pd);
      chk("delay_pd", 8'h02, {6'h00, delay_pd});
      chk("pecl_pd", 8'hd4, pecl_pd);
      chk("low_pd", 8'h09, {4'h0, low_pd});
      chk("sync_lost", 8'h01, {7'h00, sync_lost});
      @(posedge mclk);
      pll_pd_req <= 1'b0;
      dist_pd_req <= 1'b0;
      delay_sel <= 2'h3;
      pecl_pd_req <= 8'h00;
      repeat (3) @(posedge mclk);
      #1;
      chk("pll_pd", 8'h00, {7'h00, pll_pd});
      chk("delay_pd", 8'h00, {6'h00, delay_pd});
      rchk(8'h58, 8'h20);
      chk("pin_role", 8'h01, {6'h00, pin_role});
      host_u.pin(1'b0, n);
      host_u.pin(1'b1, n);
      chk("sync_lost", 8'h00, {7'h00, sync_lost});
      print_verdict();
   end
endmodule
`default_nettype wire
